// File: design/csq_sequencer.sv
/*
  Bus cycle sequencer of an 8-bit core: turns one request per cycle into
  free, fetch, operand, stack and vector cycles on the system bus, and keeps
  the program counter, stack pointer and index pair.
  Assumes memory answers a read in the same cycle the strobe is shown.
*/
// Notes on behaviour
// - A free cycle lasts one bus clock and shows as a read.
// - A program fetch reads the byte after the previously fetched one.
// - Vectors are read from the top page, high byte before low byte.
// - A stack push writes exactly one byte at the stack location.
// - A stack pop reads exactly one byte from the stack location.
// - An operand read moves one byte from memory into the core.
// - An operand write moves one byte from the core to memory.
// - Post-increment modes address from the index, then bump the index.
// - Relative mode fetches one offset byte and adds it to the counter when the branch is taken.
// - Stack modes add a byte or word offset to the stack pointer.
// - Branch targets span a signed byte from the next instruction.
`timescale 1ns/1ps
module csq_sequencer
  import csq_pkg::*;
#(
  parameter int ADDR_W = CSQ_ADDR_W,
  parameter int DATA_W = CSQ_DATA_W
) (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic cmd_valid_i,
  input wire csq_cycle_t cmd_cycle_i,
  input wire csq_mode_t cmd_mode_i,
  input wire logic [ADDR_W-1:0] cmd_offset_i,
  input wire logic [DATA_W-1:0] cmd_wdata_i,
  input wire logic [7:0] cmd_vector_i,
  input wire logic cmd_take_i,
  output logic cmd_ready_o,
  output logic [ADDR_W-1:0] bus_addr_o,
  output logic bus_rd_o,
  output logic bus_wr_o,
  output logic [DATA_W-1:0] bus_wdata_o,
  input wire logic [DATA_W-1:0] bus_rdata_i,
  output logic rsp_valid_o,
  output logic [DATA_W-1:0] rsp_data_o,
  output logic [ADDR_W-1:0] pc_o,
  output logic [ADDR_W-1:0] sp_o,
  output logic [ADDR_W-1:0] index_o
);

  csq_state_t state_q;
  logic [ADDR_W-1:0] pc_q;
  logic [ADDR_W-1:0] sp_q;
  logic [7:0] index_high_q;
  logic [7:0] index_low_q;
  logic [7:0] vector_low_q;
  logic [7:0] vector_high_q;
  logic take_q;
  logic data_read_q;
  logic [ADDR_W-1:0] bus_addr_q;
  logic bus_rd_q;
  logic bus_wr_q;
  logic [DATA_W-1:0] bus_wdata_q;
  logic [DATA_W-1:0] rsp_data_q;
  logic rsp_valid_q;
  logic [ADDR_W-1:0] ea;
  logic cmd_fire;
  logic [ADDR_W-1:0] index_pair;
  logic [ADDR_W-1:0] index_next;
  logic [ADDR_W-1:0] branch_target;

  function automatic logic is_post_increment(input csq_mode_t mode);
    is_post_increment = (mode == INDEXED_POST_INCREMENT_MODE) ||
                        (mode == INDEXED_BYTE_OFFSET_POST_INCREMENT_MODE);
  endfunction : is_post_increment

  function automatic logic is_operand(input csq_cycle_t cycle);
    is_operand = (cycle == CYC_OPERAND_READ) || (cycle == CYC_OPERAND_WRITE);
  endfunction : is_operand

  csq_ea_gen #(
    .ADDR_W(ADDR_W)
  ) u_ea_gen (
    .mode_i(cmd_mode_i),
    .index_high_i(index_high_q),
    .index_low_i(index_low_q),
    .stack_i(sp_q),
    .offset_i(cmd_offset_i),
    .addr_o(ea)
  );

  // Requests are refused while a multi-cycle sequence owns the bus.
  assign cmd_ready_o = (state_q == ST_RUN);
  assign cmd_fire = cmd_valid_i && cmd_ready_o;

  assign index_pair = ADDR_W'({index_high_q, index_low_q});
  assign index_next = index_pair + ADDR_W'(CSQ_ONE);

  // The counter already points past the offset byte when the add happens,
  // so the reach is measured from the next instruction.
  assign branch_target = pc_q + ADDR_W'({{(ADDR_W-8){bus_rdata_i[7]}}, bus_rdata_i[7:0]});

  // Sequence control.
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      state_q <= ST_RUN;
    end else begin
      case (state_q)
        ST_RUN: begin
          if (cmd_fire && cmd_cycle_i == CYC_VECTOR_FETCH) begin
            state_q <= ST_VECTOR_HIGH;
          end else if (cmd_fire && cmd_cycle_i == CYC_RELATIVE_BRANCH) begin
            state_q <= ST_RELATIVE;
          end
        end
        ST_VECTOR_HIGH: begin
          state_q <= ST_VECTOR_LOW;
        end
        ST_VECTOR_LOW: begin
          state_q <= ST_RUN;
        end
        ST_RELATIVE: begin
          state_q <= ST_RUN;
        end
        default: begin
          state_q <= ST_RUN;
        end
      endcase
    end
  end

  // Bus cycle issue: every request becomes exactly one bus cycle, except
  // a vector, which takes two.
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      bus_addr_q <= '0;
      bus_rd_q <= 1'b0;
      bus_wr_q <= 1'b0;
      bus_wdata_q <= '0;
      data_read_q <= 1'b0;
    end else begin
      bus_rd_q <= 1'b0;
      bus_wr_q <= 1'b0;
      data_read_q <= 1'b0;
      if (state_q == ST_VECTOR_HIGH) begin
        bus_addr_q <= ADDR_W'({CSQ_VECTOR_PAGE, vector_low_q + 8'h01});
        bus_rd_q <= 1'b1;
      end else if (cmd_fire) begin
        case (cmd_cycle_i)
          CYC_FREE, CYC_SET_INDEX, CYC_SET_STACK: begin
            // No data is wanted, but the bus still sees a plain read.
            bus_addr_q <= pc_q;
            bus_rd_q <= 1'b1;
          end
          CYC_PROGRAM_FETCH: begin
            bus_addr_q <= pc_q;
            bus_rd_q <= 1'b1;
            data_read_q <= 1'b1;
          end
          CYC_RELATIVE_BRANCH: begin
            bus_addr_q <= pc_q;
            bus_rd_q <= 1'b1;
          end
          CYC_OPERAND_READ: begin
            bus_addr_q <= ea;
            bus_rd_q <= 1'b1;
            data_read_q <= 1'b1;
          end
          CYC_OPERAND_WRITE: begin
            bus_addr_q <= ea;
            bus_wr_q <= 1'b1;
            bus_wdata_q <= cmd_wdata_i;
          end
          CYC_STACK_PUSH: begin
            bus_addr_q <= sp_q;
            bus_wr_q <= 1'b1;
            bus_wdata_q <= cmd_wdata_i;
          end
          CYC_STACK_POP: begin
            // The pointer rests on the next free byte, so a pop reads one above it.
            bus_addr_q <= sp_q + ADDR_W'(CSQ_ONE);
            bus_rd_q <= 1'b1;
            data_read_q <= 1'b1;
          end
          CYC_VECTOR_FETCH: begin
            bus_addr_q <= ADDR_W'({CSQ_VECTOR_PAGE, cmd_vector_i});
            bus_rd_q <= 1'b1;
          end
          default: begin
            bus_addr_q <= pc_q;
            bus_rd_q <= 1'b1;
          end
        endcase
      end
    end
  end

  // Vector address and captured high byte.
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      vector_low_q <= 8'h00;
      vector_high_q <= 8'h00;
    end else begin
      if (cmd_fire && cmd_cycle_i == CYC_VECTOR_FETCH) begin
        vector_low_q <= cmd_vector_i;
      end
      if (state_q == ST_VECTOR_HIGH) begin
        vector_high_q <= bus_rdata_i[7:0];
      end
    end
  end

  // Branch decision is held while the offset byte is on the bus.
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      take_q <= 1'b0;
    end else if (cmd_fire && cmd_cycle_i == CYC_RELATIVE_BRANCH) begin
      take_q <= cmd_take_i;
    end
  end

  // Program counter.
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      pc_q <= ADDR_W'(CSQ_PC_RESET);
    end else begin
      case (state_q)
        ST_RUN: begin
          if (cmd_fire && (cmd_cycle_i == CYC_PROGRAM_FETCH || cmd_cycle_i == CYC_RELATIVE_BRANCH)) begin
            pc_q <= pc_q + ADDR_W'(CSQ_ONE);
          end
        end
        ST_RELATIVE: begin
          if (take_q) begin
            pc_q <= branch_target;
          end
        end
        ST_VECTOR_LOW: begin
          pc_q <= ADDR_W'({vector_high_q, bus_rdata_i[7:0]});
        end
        default: begin
          pc_q <= pc_q;
        end
      endcase
    end
  end

  // Stack pointer.
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      sp_q <= ADDR_W'(CSQ_SP_RESET);
    end else if (cmd_fire) begin
      if (cmd_cycle_i == CYC_STACK_PUSH) begin
        sp_q <= sp_q - ADDR_W'(CSQ_ONE);
      end else if (cmd_cycle_i == CYC_STACK_POP) begin
        sp_q <= sp_q + ADDR_W'(CSQ_ONE);
      end else if (cmd_cycle_i == CYC_SET_STACK) begin
        sp_q <= cmd_offset_i;
      end
    end
  end

  // Index pair; the bump lands on the same edge that registers the access address,
  // so the access itself always sees the old index.
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      index_high_q <= CSQ_HX_RESET[CSQ_INDEX_HIGH_MSB:CSQ_INDEX_HIGH_LSB];
      index_low_q <= CSQ_HX_RESET[CSQ_INDEX_LOW_MSB:CSQ_INDEX_LOW_LSB];
    end else if (cmd_fire) begin
      if (is_operand(cmd_cycle_i) && is_post_increment(cmd_mode_i)) begin
        index_high_q <= index_next[CSQ_INDEX_HIGH_MSB:CSQ_INDEX_HIGH_LSB];
        index_low_q <= index_next[CSQ_INDEX_LOW_MSB:CSQ_INDEX_LOW_LSB];
      end else if (cmd_cycle_i == CYC_SET_INDEX) begin
        index_high_q <= cmd_offset_i[CSQ_INDEX_HIGH_MSB:CSQ_INDEX_HIGH_LSB];
        index_low_q <= cmd_offset_i[CSQ_INDEX_LOW_MSB:CSQ_INDEX_LOW_LSB];
      end
    end
  end

  // Read data returned to the core: one byte per data read cycle.
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      rsp_valid_q <= 1'b0;
      rsp_data_q <= '0;
    end else begin
      rsp_valid_q <= data_read_q;
      if (data_read_q) begin
        rsp_data_q <= bus_rdata_i;
      end
    end
  end

  assign bus_addr_o = bus_addr_q;
  assign bus_rd_o = bus_rd_q;
  assign bus_wr_o = bus_wr_q;
  assign bus_wdata_o = bus_wdata_q;
  assign rsp_valid_o = rsp_valid_q;
  assign rsp_data_o = rsp_data_q;
  assign pc_o = pc_q;
  assign sp_o = sp_q;
  assign index_o = index_pair;

endmodule : csq_sequencer

// File: design/csq_pkg.sv
/*
  Constants and enumerations shared by the core bus cycle sequencer and its
  effective address generator.
  Assumes an 8-bit data path and a 16-bit address space on one bus clock.
*/
package csq_pkg;

  localparam int CSQ_ADDR_W = 16;
  localparam int CSQ_DATA_W = 8;

  // Reset values of the core pointers.
  localparam logic [15:0] CSQ_PC_RESET = 16'h0000;
  localparam logic [15:0] CSQ_SP_RESET = 16'h00ff;
  localparam logic [15:0] CSQ_HX_RESET = 16'h0000;

  // Vectors live in the top page of memory.
  localparam logic [7:0] CSQ_VECTOR_PAGE = 8'hff;
  // Direct addressing reaches the bottom page only.
  localparam logic [7:0] CSQ_DIRECT_PAGE = 8'h00;

  // Field positions inside the 16-bit index pair.
  localparam int CSQ_INDEX_HIGH_MSB = 15;
  localparam int CSQ_INDEX_HIGH_LSB = 8;
  localparam int CSQ_INDEX_LOW_MSB = 7;
  localparam int CSQ_INDEX_LOW_LSB = 0;

  // Bus cycles taken by a free request and by a vector request.
  localparam int CSQ_FREE_CYCLES = 1;
  localparam int CSQ_VECTOR_CYCLES = 2;

  localparam logic [15:0] CSQ_ONE = 16'h0001;

  typedef enum logic [3:0] {
    CYC_FREE = 4'h0,
    CYC_PROGRAM_FETCH = 4'h1,
    CYC_OPERAND_READ = 4'h2,
    CYC_OPERAND_WRITE = 4'h3,
    CYC_STACK_PUSH = 4'h4,
    CYC_STACK_POP = 4'h5,
    CYC_VECTOR_FETCH = 4'h6,
    CYC_RELATIVE_BRANCH = 4'h7,
    CYC_SET_INDEX = 4'h8,
    CYC_SET_STACK = 4'h9
  } csq_cycle_t;

  typedef enum logic [3:0] {
    DIRECT_MODE = 4'h0,
    EXTENDED_MODE = 4'h1,
    INDEXED_MODE = 4'h2,
    INDEXED_BYTE_OFFSET_MODE = 4'h3,
    INDEXED_WORD_OFFSET_MODE = 4'h4,
    INDEXED_POST_INCREMENT_MODE = 4'h5,
    INDEXED_BYTE_OFFSET_POST_INCREMENT_MODE = 4'h6,
    STACK_BYTE_OFFSET_MODE = 4'h7,
    STACK_WORD_OFFSET_MODE = 4'h8
  } csq_mode_t;

  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_VECTOR_HIGH = 2'b01,
    ST_VECTOR_LOW = 2'b10,
    ST_RELATIVE = 2'b11
  } csq_state_t;

endpackage : csq_pkg

// File: design/csq_ea_gen.sv
/*
  Effective address generator for operand cycles.
  Assumes the caller registers the result before it reaches the bus.
*/
`timescale 1ns/1ps
module csq_ea_gen
  import csq_pkg::*;
#(
  parameter int ADDR_W = CSQ_ADDR_W
) (
  input wire csq_mode_t mode_i,
  input wire logic [7:0] index_high_i,
  input wire logic [7:0] index_low_i,
  input wire logic [ADDR_W-1:0] stack_i,
  input wire logic [ADDR_W-1:0] offset_i,
  output logic [ADDR_W-1:0] addr_o
);

  logic [ADDR_W-1:0] index_base;
  logic [ADDR_W-1:0] byte_offset;

  // The index pair is joined high byte first into one base.
  assign index_base = ADDR_W'({index_high_i, index_low_i});
  // Byte offsets are unsigned and zero extended.
  assign byte_offset = ADDR_W'(offset_i[7:0]);

  always_comb begin
    addr_o = index_base;
    case (mode_i)
      DIRECT_MODE: begin
        addr_o = ADDR_W'({CSQ_DIRECT_PAGE, offset_i[7:0]});
      end
      EXTENDED_MODE: begin
        addr_o = offset_i;
      end
      INDEXED_MODE: begin
        addr_o = index_base;
      end
      INDEXED_BYTE_OFFSET_MODE: begin
        addr_o = index_base + byte_offset;
      end
      INDEXED_WORD_OFFSET_MODE: begin
        addr_o = index_base + offset_i;
      end
      INDEXED_POST_INCREMENT_MODE: begin
        addr_o = index_base;
      end
      INDEXED_BYTE_OFFSET_POST_INCREMENT_MODE: begin
        addr_o = index_base + byte_offset;
      end
      STACK_BYTE_OFFSET_MODE: begin
        addr_o = stack_i + byte_offset;
      end
      STACK_WORD_OFFSET_MODE: begin
        addr_o = stack_i + offset_i;
      end
      default: begin
        addr_o = index_base;
      end
    endcase
  end

endmodule : csq_ea_gen

// File: testbench/csq_seq_monitor.sv
/* Concurrent checks on the sequencer ports, with the bind placed after the module.
   Assumes one clock domain and a synchronous active-high reset. */
`timescale 1ns/1ps
module csq_seq_monitor
  import csq_pkg::*;
(
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic cmd_valid_i,
  input wire csq_cycle_t cmd_cycle_i,
  input wire csq_mode_t cmd_mode_i,
  input wire logic [15:0] cmd_offset_i,
  input wire logic [7:0] cmd_wdata_i,
  input wire logic [7:0] cmd_vector_i,
  input wire logic cmd_take_i,
  input wire logic cmd_ready_o,
  input wire logic [15:0] bus_addr_o,
  input wire logic bus_rd_o,
  input wire logic bus_wr_o,
  input wire logic [7:0] bus_wdata_o,
  input wire logic [7:0] bus_rdata_i,
  input wire logic rsp_valid_o,
  input wire logic [7:0] rsp_data_o,
  input wire logic [15:0] pc_o,
  input wire logic [15:0] sp_o,
  input wire logic [15:0] index_o
);
  logic take;
  logic [15:0] off_b;
  logic [15:0] rel_ext;
  assign take = cmd_valid_i && cmd_ready_o;
  assign off_b = {8'h00, cmd_offset_i[7:0]};
  assign rel_ext = {{8{bus_rdata_i[7]}}, bus_rdata_i};
  default clocking @(posedge clock_i);
  endclocking
  default disable iff (reset_i);
  chk_free_as_read:
    assert property (take && cmd_cycle_i == CYC_FREE |=> bus_rd_o && !bus_wr_o && bus_addr_o == $past(pc_o))
    else $error("free cycle is not a read at the counter");
  chk_fetch_next:
    assert property (take && cmd_cycle_i == CYC_PROGRAM_FETCH |=> bus_rd_o && bus_addr_o == $past(pc_o)
      && pc_o == $past(pc_o) + 16'h0001) else $error("fetch address or counter step wrong");
  chk_vector_order:
    assert property (take && cmd_cycle_i == CYC_VECTOR_FETCH |=> !cmd_ready_o && bus_rd_o
      && bus_addr_o == {8'hff, $past(cmd_vector_i)} ##1 !cmd_ready_o && bus_rd_o
      && bus_addr_o == {8'hff, $past(cmd_vector_i, 2) + 8'h01} ##1 pc_o == {$past(bus_rdata_i, 2), $past(bus_rdata_i)})
    else $error("vector read order or counter load wrong");
  chk_push_write:
    assert property (take && cmd_cycle_i == CYC_STACK_PUSH |=> bus_wr_o && !bus_rd_o && bus_addr_o == $past(sp_o)
      && bus_wdata_o == $past(cmd_wdata_i) && sp_o == $past(sp_o) - 16'h0001) else $error("push write wrong");
  chk_pop_read:
    assert property (take && cmd_cycle_i == CYC_STACK_POP |=> bus_rd_o && !bus_wr_o
      && bus_addr_o == $past(sp_o) + 16'h0001 && sp_o == $past(sp_o) + 16'h0001) else $error("pop read wrong");
  chk_write_operand:
    assert property (take && cmd_cycle_i == CYC_OPERAND_WRITE |=> bus_wr_o && !bus_rd_o
      && bus_wdata_o == $past(cmd_wdata_i)) else $error("operand write wrong");
  chk_read_returns:
    assert property (take && cmd_cycle_i inside {CYC_OPERAND_READ, CYC_PROGRAM_FETCH, CYC_STACK_POP} |=> bus_rd_o
      ##1 rsp_valid_o && rsp_data_o == $past(bus_rdata_i)) else $error("read byte not returned");
  chk_post_increment:
    assert property (take && cmd_cycle_i inside {CYC_OPERAND_READ, CYC_OPERAND_WRITE}
      && cmd_mode_i == INDEXED_BYTE_OFFSET_POST_INCREMENT_MODE |=> bus_addr_o == $past(index_o) + $past(off_b)
      && index_o == $past(index_o) + 16'h0001) else $error("post increment address or bump wrong");
  chk_branch_target:
    assert property (take && cmd_cycle_i == CYC_RELATIVE_BRANCH |=> !cmd_ready_o && bus_rd_o
      && bus_addr_o == $past(pc_o)
      ##1 pc_o == $past(pc_o, 2) + 16'h0001 + ($past(cmd_take_i, 2) ? $past(rel_ext) : 16'h0000))
    else $error("branch target wrong");
  chk_stack_offset:
    assert property (take && cmd_cycle_i inside {CYC_OPERAND_READ, CYC_OPERAND_WRITE}
      && cmd_mode_i inside {STACK_BYTE_OFFSET_MODE, STACK_WORD_OFFSET_MODE} |=> bus_addr_o == $past(sp_o)
      + ($past(cmd_mode_i) == STACK_WORD_OFFSET_MODE ? $past(cmd_offset_i) : $past(off_b)))
    else $error("stack offset address wrong");
  cov_vector: cover property (take && cmd_cycle_i == CYC_VECTOR_FETCH);
  cov_branch_taken: cover property (take && cmd_cycle_i == CYC_RELATIVE_BRANCH && cmd_take_i);
  cov_pop: cover property (take && cmd_cycle_i == CYC_STACK_POP);
endmodule : csq_seq_monitor

bind csq_sequencer csq_seq_monitor u_csq_seq_monitor (
  .clock_i(clock_i), .reset_i(reset_i), .cmd_valid_i(cmd_valid_i), .cmd_cycle_i(cmd_cycle_i),
  .cmd_mode_i(cmd_mode_i), .cmd_offset_i(cmd_offset_i), .cmd_wdata_i(cmd_wdata_i), .cmd_vector_i(cmd_vector_i),
  .cmd_take_i(cmd_take_i), .cmd_ready_o(cmd_ready_o), .bus_addr_o(bus_addr_o), .bus_rd_o(bus_rd_o),
  .bus_wr_o(bus_wr_o), .bus_wdata_o(bus_wdata_o), .bus_rdata_i(bus_rdata_i), .rsp_valid_o(rsp_valid_o),
  .rsp_data_o(rsp_data_o), .pc_o(pc_o), .sp_o(sp_o), .index_o(index_o)
);

// File: testbench/csq_mem_model.sv
/* Behavioural memory on the system bus: answers a read in the same cycle.
   Assumes the sequencer samples read data at the edge closing the cycle. */
`timescale 1ns/1ps
module csq_mem_model (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic [15:0] addr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o
);
  logic [7:0] last_q;
  // Outside reads the bus toggles each cycle, so stale data never matches by luck.
  assign rdata_o = rd_i ? (addr_i[7:0] ^ addr_i[15:8] ^ 8'h96) : ~last_q;
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      last_q <= 8'h00;
    end else begin
      last_q <= rdata_o;
    end
  end
endmodule : csq_mem_model

// File: testbench/tb_cpu_bus_cycle_sequencer.sv
/* Self-checking bench for the bus cycle sequencer with a memory model.
   Assumes the sequencer timing of one strobe cycle and a response one cycle later. */
`timescale 1ns/1ps
module tb_cpu_bus_cycle_sequencer;
  import csq_pkg::*;
  logic clock_i = 1'b0;
  logic reset_i = 1'b1;
  logic cmd_valid_i = 1'b0;
  csq_cycle_t cmd_cycle_i = CYC_FREE;
  csq_mode_t cmd_mode_i = DIRECT_MODE;
  logic [15:0] cmd_offset_i = 16'h0000;
  logic [7:0] cmd_wdata_i = 8'h00;
  logic [7:0] cmd_vector_i = 8'h00;
  logic cmd_take_i = 1'b0;
  logic cmd_ready_o, bus_rd_o, bus_wr_o, rsp_valid_o;
  logic [15:0] bus_addr_o, pc_o, sp_o, index_o;
  logic [7:0] bus_wdata_o, bus_rdata_i, rsp_data_o;
  logic [15:0] pc_m, sp_m, ix_m;
  int error_cnt = 0;
  int n_tests = 0;
  int seed = 5134;
  always #25 clock_i = ~clock_i;

  csq_sequencer u_csq_sequencer (
    .clock_i(clock_i), .reset_i(reset_i), .cmd_valid_i(cmd_valid_i), .cmd_cycle_i(cmd_cycle_i),
    .cmd_mode_i(cmd_mode_i), .cmd_offset_i(cmd_offset_i), .cmd_wdata_i(cmd_wdata_i), .cmd_vector_i(cmd_vector_i),
    .cmd_take_i(cmd_take_i), .cmd_ready_o(cmd_ready_o), .bus_addr_o(bus_addr_o), .bus_rd_o(bus_rd_o),
    .bus_wr_o(bus_wr_o), .bus_wdata_o(bus_wdata_o), .bus_rdata_i(bus_rdata_i), .rsp_valid_o(rsp_valid_o),
    .rsp_data_o(rsp_data_o), .pc_o(pc_o), .sp_o(sp_o), .index_o(index_o)
  );
  csq_mem_model u_csq_mem_model (
    .clock_i(clock_i), .reset_i(reset_i), .addr_i(bus_addr_o), .rd_i(bus_rd_o), .rdata_o(bus_rdata_i)
  );

  function automatic logic [7:0] mem_byte(logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h96;
  endfunction : mem_byte

  function automatic logic [15:0] ea_of(csq_mode_t m, logic [15:0] o);
    case (m)
      DIRECT_MODE: return {8'h00, o[7:0]};
      EXTENDED_MODE: return o;
      INDEXED_MODE, INDEXED_POST_INCREMENT_MODE: return ix_m;
      INDEXED_BYTE_OFFSET_MODE, INDEXED_BYTE_OFFSET_POST_INCREMENT_MODE: return ix_m + {8'h00, o[7:0]};
      INDEXED_WORD_OFFSET_MODE: return ix_m + o;
      STACK_BYTE_OFFSET_MODE: return sp_m + {8'h00, o[7:0]};
      default: return sp_m + o;
    endcase
  endfunction : ea_of

  task automatic check_word(string what, logic [15:0] exp, logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check_word

  task automatic check_byte(string what, logic [7:0] exp, logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check_byte

  task automatic check_bit(string what, logic exp, logic got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask : check_bit

  task automatic give_verdict();
    $display("Comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : give_verdict

  task automatic run_cmd(csq_cycle_t c, csq_mode_t m, logic [15:0] o, logic [7:0] w, logic [7:0] v, logic t);
    logic [15:0] a;
    logic [7:0] d;
    logic wr;
    logic rsp;
    @(posedge clock_i);
    cmd_valid_i <= 1'b1;
    cmd_cycle_i <= c;
    cmd_mode_i <= m;
    cmd_offset_i <= o;
    cmd_wdata_i <= w;
    cmd_vector_i <= v;
    cmd_take_i <= t;
    @(posedge clock_i);
    cmd_valid_i <= 1'b0;
    a = pc_m;
    case (c)
      CYC_PROGRAM_FETCH, CYC_RELATIVE_BRANCH: pc_m = pc_m + 16'h0001;
      CYC_OPERAND_READ, CYC_OPERAND_WRITE: begin
        a = ea_of(m, o);
        if (m inside {INDEXED_POST_INCREMENT_MODE, INDEXED_BYTE_OFFSET_POST_INCREMENT_MODE}) begin
          ix_m = ix_m + 16'h0001;
        end
      end
      CYC_STACK_PUSH: begin
        a = sp_m;
        sp_m = sp_m - 16'h0001;
      end
      CYC_STACK_POP: begin
        sp_m = sp_m + 16'h0001;
        a = sp_m;
      end
      CYC_VECTOR_FETCH: a = {8'hff, v};
      CYC_SET_INDEX: ix_m = o;
      CYC_SET_STACK: sp_m = o;
      default: a = pc_m;
    endcase
    wr = c inside {CYC_OPERAND_WRITE, CYC_STACK_PUSH};
    rsp = c inside {CYC_PROGRAM_FETCH, CYC_OPERAND_READ, CYC_STACK_POP};
    d = mem_byte(a);
    @(negedge clock_i);
    check_word("bus_addr", a, bus_addr_o);
    check_bit("bus_rd", !wr, bus_rd_o);
    check_bit("bus_wr", wr, bus_wr_o);
    if (wr) check_byte("bus_wdata", w, bus_wdata_o);
    check_bit("ready_busy", !(c inside {CYC_VECTOR_FETCH, CYC_RELATIVE_BRANCH}), cmd_ready_o);
    if (c == CYC_VECTOR_FETCH) begin
      @(negedge clock_i);
      check_word("vector_low_addr", {8'hff, v + 8'h01}, bus_addr_o);
      check_bit("vector_ready", 1'b0, cmd_ready_o);
      pc_m = {d, mem_byte({8'hff, v + 8'h01})};
    end
    if (c == CYC_RELATIVE_BRANCH && t) pc_m = pc_m + {{8{d[7]}}, d};
    @(negedge clock_i);
    check_bit("rsp_valid", rsp, rsp_valid_o);
    if (rsp) check_byte("rsp_data", d, rsp_data_o);
    check_bit("bus_rd_drop", 1'b0, bus_rd_o);
    check_bit("ready", 1'b1, cmd_ready_o);
    check_word("pc", pc_m, pc_o);
    check_word("sp", sp_m, sp_o);
    check_word("index", ix_m, index_o);
  endtask : run_cmd

  initial begin
    pc_m = CSQ_PC_RESET;
    sp_m = CSQ_SP_RESET;
    ix_m = CSQ_HX_RESET;
    repeat (20) @(posedge clock_i);
    reset_i <= 1'b0;
    @(negedge clock_i);
    check_word("reset_sp", sp_m, sp_o);
    // Every cycle kind once, then every mode from an index that wraps.
    for (int k = 0; k < 10; k++) begin
      run_cmd(csq_cycle_t'(4'(k)), INDEXED_MODE, 16'hfffe, 8'ha5, 8'hfe, 1'b1);
    end
    for (int k = 0; k < 9; k++) begin
      run_cmd(CYC_SET_INDEX, DIRECT_MODE, 16'hffff, 8'h00, 8'h00, 1'b0);
      run_cmd(CYC_OPERAND_READ, csq_mode_t'(4'(k)), 16'h80ff, 8'h00, 8'h00, 1'b0);
      run_cmd(CYC_OPERAND_WRITE, csq_mode_t'(4'(k)), 16'h7f01, 8'h3c, 8'h00, 1'b0);
    end
    for (int k = 0; k < 400; k++) begin
      run_cmd(csq_cycle_t'(4'($unsigned($random(seed)) % 10)), csq_mode_t'(4'($unsigned($random(seed)) % 9)),
        16'($random(seed)), 8'($random(seed)), 8'($random(seed)) & 8'hfe, 1'($random(seed)));
    end
    // A reset in mid-run must restore every pointer, whatever the random run left behind.
    @(posedge clock_i);
    reset_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    reset_i <= 1'b0;
    pc_m = CSQ_PC_RESET;
    sp_m = CSQ_SP_RESET;
    ix_m = CSQ_HX_RESET;
    @(negedge clock_i);
    check_word("reset_pc", pc_m, pc_o);
    check_word("reset_sp", sp_m, sp_o);
    check_word("reset_index", ix_m, index_o);
    check_bit("reset_ready", 1'b1, cmd_ready_o);
    check_bit("reset_rd", 1'b0, bus_rd_o);
    check_bit("reset_wr", 1'b0, bus_wr_o);
    run_cmd(CYC_PROGRAM_FETCH, DIRECT_MODE, 16'h0000, 8'h00, 8'h00, 1'b0);
    run_cmd(CYC_STACK_POP, DIRECT_MODE, 16'h0000, 8'h00, 8'h00, 1'b0);
    give_verdict();
  end

  initial begin
    #(50 * 20000);
    error_cnt++;
    give_verdict();
  end
endmodule : tb_cpu_bus_cycle_sequencer
